/* alu_exec_pkg.sv */
// Package for the add/AND instruction execution block.
// Assumes one core clock, four core clocks per instruction cycle.
package alu_exec_pkg;

  localparam int          ADDR_W           = 14;
  localparam int          PHASES_PER_INSTR = 4;
  localparam int          DEST_BIT         = 9;
  localparam int          ACCESS_BIT       = 8;
  localparam logic [5:0]  OPC_ADD_FILE     = 6'h09;
  localparam logic [5:0]  OPC_ADD_CARRY    = 6'h08;
  localparam logic [7:0]  OPC_AND_LIT      = 8'h0B;
  localparam logic [7:0]  IDX_OFFSET_MAX   = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT     = 8'h60;
  localparam logic [13:0] ACCESS_LOW_BASE  = 14'h0000;
  localparam logic [13:0] ACCESS_HIGH_BASE = 14'h3F00;
  localparam logic [7:0]  WREG_RESET       = 8'h00;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;

  typedef enum logic [1:0] {OP_NONE, OP_ADD, OP_ADDC, OP_AND} op_type;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_type;

  // Opcode decode of one program word
  function automatic op_type op_decode(input logic [15:0] word);
    op_type op;
    op = OP_NONE;
    if (word[15:10] == OPC_ADD_FILE) begin
      op = OP_ADD;
    end else if (word[15:10] == OPC_ADD_CARRY) begin
      op = OP_ADDC;
    end else if (word[15:8] == OPC_AND_LIT) begin
      op = OP_AND;
    end
    return op;
  endfunction

endpackage

/* addr_resolve.sv */
// File address resolution: access bank, banked or indexed literal offset.
// Assumes the offset register and bank select are stable during decode.
`timescale 1ns/1ps
`default_nettype none
module addr_resolve
  import alu_exec_pkg::*;
(
  // Instruction fields
  input  wire logic [7:0]        file_addr,
  input  wire logic              access_sel,
  // Addressing state
  input  wire logic              ext_set_en,
  input  wire logic [5:0]        bank_select_register,
  input  wire logic [ADDR_W-1:0] fsr2,
  // Result
  output logic      [ADDR_W-1:0] data_addr,
  output logic                   indexed
);

  always_comb begin
    indexed = ext_set_en && !access_sel && (file_addr <= IDX_OFFSET_MAX);
    if (indexed) begin
      data_addr = fsr2 + {6'h00, file_addr};
    end else if (!access_sel) begin
      data_addr = (file_addr < ACCESS_SPLIT) ? (ACCESS_LOW_BASE | {6'h00, file_addr})
                                             : (ACCESS_HIGH_BASE | {6'h00, file_addr});
    end else begin
      data_addr = {bank_select_register, file_addr};
    end
  end

endmodule
`default_nettype wire

/* add_logic_unit.sv */
// Eight-bit adder and AND unit with status flag outputs.
// Purely combinational; the caller decides which flags to keep.
`timescale 1ns/1ps
`default_nettype none
module add_logic_unit
  import alu_exec_pkg::*;
(
  // Operands
  input  wire op_type     op,
  input  wire logic [7:0] opa,
  input  wire logic [7:0] opb,
  input  wire logic       carry_in,
  // Result and flags
  output logic      [7:0] result,
  output logic            neg,
  output logic            ovf,
  output logic            cry,
  output logic            dcy
);

  logic [8:0] sum9;
  logic [4:0] low5;
  logic       cin;

  always_comb begin
    cin    = (op == OP_ADDC) ? carry_in : 1'b0;
    sum9   = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
    low5   = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    result = (op == OP_AND) ? (opa & opb) : sum9[7:0];
    neg    = result[7];
    ovf    = (opa[7] == opb[7]) && (sum9[7] != opa[7]);
    cry    = sum9[8];
    dcy    = low5[4];
  end

endmodule
`default_nettype wire

/* add_logic_exec.sv */
// Execution core for add W to file, add with carry, and AND literal.
// Assumes data memory answers combinationally to mem_addr within a cycle.
// Operation
// - add-to-file adds W and addressed file register, delivers to destination
// - destination 0 writes sum to W, file register untouched
// - destination 1 writes sum back into addressed file register
// - add-to-file updates N, OV, C, DC, Z from result
// - access bit 0 resolves address in access bank
// - access bit 1 uses bank select register to choose bank
// - extended set, access 0, address up to 95 uses indexed literal offset
// - one word, one cycle: decode, read, process, write quarters
// - add-with-carry sums W, carry flag and addressed location
// - add-with-carry decoded from 001000, then d, a, eight-bit address
// - add-with-carry destination 1 to file, 0 to W
// - add-with-carry updates N, OV, C, DC, Z from result
// - AND-literal ANDs W with eight-bit literal into W
`timescale 1ns/1ps
`default_nettype none
module add_logic_exec
  import alu_exec_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Instruction word, sampled in Q1
  input  wire logic [15:0]       instr,
  input  wire logic              instr_valid,
  // Addressing state
  input  wire logic              ext_set_en,
  input  wire logic [5:0]        bank_select_register,
  input  wire logic [ADDR_W-1:0] fsr2,
  // Data memory
  output logic      [ADDR_W-1:0] mem_addr,
  output logic                   mem_rd,
  output logic                   mem_we,
  output logic      [7:0]        mem_wdata,
  input  wire logic [7:0]        mem_rdata,
  // Working register and flags
  output logic      [7:0]        wreg,
  output logic                   negative_flag,
  output logic                   overflow_flag,
  output logic                   carry_flag,
  output logic                   digit_carry_flag,
  output logic                   zero_flag,
  // Sequencing
  output logic      [1:0]        q_phase,
  output logic                   instr_done
);

  phase_type         phase_reg;
  op_type            op_reg;
  op_type            dec_op;
  logic              dest_file_reg;
  logic [7:0]        literal_reg;
  logic [7:0]        operand_reg;
  logic [7:0]        result_reg;
  logic [7:0]        wreg_reg;
  logic              n_reg, ov_reg, c_reg, dc_reg, z_reg;
  logic              ov_next, c_next, dc_next;
  logic              ov_q3, c_q3, dc_q3;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic              mem_rd_reg, mem_we_reg, done_reg;
  logic [7:0]        mem_wdata_reg;
  logic [7:0]        alu_b;
  logic [7:0]        alu_result;

  assign dec_op = instr_valid ? op_decode(instr) : OP_NONE;
  assign alu_b  = (op_reg == OP_AND) ? literal_reg : operand_reg;

  addr_resolve u_addr (
    .file_addr            (instr[7:0]),
    .access_sel           (instr[ACCESS_BIT]),
    .ext_set_en           (ext_set_en),
    .bank_select_register (bank_select_register),
    .fsr2                 (fsr2),
    .data_addr            (addr_next),
    .indexed              ()
  );

  add_logic_unit u_alu (
    .op       (op_reg),
    .opa      (wreg_reg),
    .opb      (alu_b),
    .carry_in (c_reg),
    .result   (alu_result),
    .neg      (),
    .ovf      (ov_next),
    .cry      (c_next),
    .dcy      (dc_next)
  );

  // Quarter phase sequencer, one instruction per four clocks
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_reg <= PH_Q1;
    end else begin
      case (phase_reg)
        PH_Q1:   phase_reg <= PH_Q2;
        PH_Q2:   phase_reg <= PH_Q3;
        PH_Q3:   phase_reg <= PH_Q4;
        PH_Q4:   phase_reg <= PH_Q1;
        default: phase_reg <= PH_Q1;
      endcase
    end
  end

  // Decode in Q1
  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_reg        <= OP_NONE;
      dest_file_reg <= 1'b0;
      literal_reg   <= BYTE_ZERO;
    end else if (phase_reg == PH_Q1) begin
      op_reg        <= dec_op;
      dest_file_reg <= (dec_op == OP_ADD || dec_op == OP_ADDC) && instr[DEST_BIT];
      literal_reg   <= instr[7:0];
    end
  end

  // File read: address set at Q1, data taken at Q2
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_addr_reg <= '0;
      mem_rd_reg   <= 1'b0;
      operand_reg  <= BYTE_ZERO;
    end else begin
      if (phase_reg == PH_Q1) begin
        mem_addr_reg <= addr_next;
        mem_rd_reg   <= (dec_op == OP_ADD || dec_op == OP_ADDC);
      end else begin
        mem_rd_reg   <= 1'b0;
      end
      if (phase_reg == PH_Q2) begin
        operand_reg <= mem_rdata;
      end
    end
  end

  // Process in Q3, file write strobe stands through Q4
  always_ff @(posedge core_clk) begin
    if (rst) begin
      result_reg    <= BYTE_ZERO;
      mem_we_reg    <= 1'b0;
      mem_wdata_reg <= BYTE_ZERO;
    end else if (phase_reg == PH_Q3) begin
      result_reg    <= alu_result;
      mem_we_reg    <= dest_file_reg;
      mem_wdata_reg <= alu_result;
    end else begin
      mem_we_reg    <= 1'b0;
    end
  end

  // Write W and flags at the end of Q4
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wreg_reg <= WREG_RESET;
      n_reg    <= 1'b0;
      ov_reg   <= 1'b0;
      c_reg    <= 1'b0;
      dc_reg   <= 1'b0;
      z_reg    <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= (phase_reg == PH_Q4) && (op_reg != OP_NONE);
      if (phase_reg == PH_Q4 && op_reg != OP_NONE) begin
        if (!dest_file_reg) begin
          wreg_reg <= result_reg;
        end
        n_reg <= result_reg[7];
        z_reg <= (result_reg == BYTE_ZERO);
        if (op_reg != OP_AND) begin
          ov_reg <= ov_q3;
          c_reg  <= c_q3;
          dc_reg <= dc_q3;
        end
      end
    end
  end

  // Arithmetic flags held from Q3
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ov_q3 <= 1'b0;
      c_q3  <= 1'b0;
      dc_q3 <= 1'b0;
    end else if (phase_reg == PH_Q3) begin
      ov_q3 <= ov_next;
      c_q3  <= c_next;
      dc_q3 <= dc_next;
    end
  end

  assign mem_addr         = mem_addr_reg;
  assign mem_rd           = mem_rd_reg;
  assign mem_we           = mem_we_reg;
  assign mem_wdata        = mem_wdata_reg;
  assign wreg             = wreg_reg;
  assign negative_flag    = n_reg;
  assign overflow_flag    = ov_reg;
  assign carry_flag       = c_reg;
  assign digit_carry_flag = dc_reg;
  assign zero_flag        = z_reg;
  assign q_phase          = phase_reg;
  assign instr_done       = done_reg;

  // Checks
  sequence s_quarters;
    phase_reg == PH_Q2 ##1 phase_reg == PH_Q3 ##1 phase_reg == PH_Q4 ##1 phase_reg == PH_Q1;
  endsequence

  sequence s_decode_add_to_w;
    phase_reg == PH_Q1 && (dec_op == OP_ADD || dec_op == OP_ADDC) && !instr[DEST_BIT];
  endsequence

  property p_quarters;
    @(posedge core_clk) disable iff (rst) phase_reg == PH_Q1 |=> s_quarters;
  endproperty
  a_quarters: assert property (p_quarters) else $error("quarter phase order broken");

  property p_w_dest_no_write;
    @(posedge core_clk) disable iff (rst) s_decode_add_to_w |=> !mem_we_reg [*4];
  endproperty
  a_w_dest_no_write: assert property (p_w_dest_no_write) else $error("file written for W dest");

  property p_w_dest_result;
    @(posedge core_clk) disable iff (rst)
      s_decode_add_to_w ##3 1'b1 |=> wreg_reg == $past(result_reg);
  endproperty
  a_w_dest_result: assert property (p_w_dest_result) else $error("W not loaded with sum");

  property p_file_dest;
    @(posedge core_clk) disable iff (rst)
      phase_reg == PH_Q1 && (dec_op == OP_ADD || dec_op == OP_ADDC) && instr[DEST_BIT]
      |=> ##2 mem_we_reg && mem_wdata_reg == result_reg ##1 !mem_we_reg;
  endproperty
  a_file_dest: assert property (p_file_dest) else $error("file dest write missing");

  property p_add_sum;
    @(posedge core_clk) disable iff (rst)
      phase_reg == PH_Q3 && op_reg == OP_ADD |=> result_reg == 8'(wreg_reg + operand_reg);
  endproperty
  a_add_sum: assert property (p_add_sum) else $error("add sum wrong");

  property p_addc_sum;
    @(posedge core_clk) disable iff (rst)
      phase_reg == PH_Q3 && op_reg == OP_ADDC
      |=> result_reg == 8'(wreg_reg + operand_reg + {7'h00, c_reg});
  endproperty
  a_addc_sum: assert property (p_addc_sum) else $error("add with carry sum wrong");

  property p_addc_decode;
    @(posedge core_clk) disable iff (rst)
      phase_reg == PH_Q1 && instr_valid && instr[15:10] == 6'h08 |=> op_reg == OP_ADDC;
  endproperty
  a_addc_decode: assert property (p_addc_decode) else $error("add with carry not decoded");

  property p_and_flags;
    @(posedge core_clk) disable iff (rst)
      phase_reg == PH_Q4 && op_reg == OP_AND
      |=> $stable(c_reg) && $stable(ov_reg) && $stable(dc_reg) && z_reg == (wreg_reg == 8'h00);
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("AND literal flags wrong");

  property p_and_result;
    @(posedge core_clk) disable iff (rst)
      phase_reg == PH_Q3 && op_reg == OP_AND |=> ##1 wreg_reg == $past(wreg_reg & literal_reg, 2);
  endproperty
  a_and_result: assert property (p_and_result) else $error("AND literal result wrong");

  property p_add_zero;
    @(posedge core_clk) disable iff (rst)
      phase_reg == PH_Q4 && (op_reg == OP_ADD || op_reg == OP_ADDC)
      |=> z_reg == ($past(result_reg) == 8'h00) && n_reg == $past(result_reg[7]);
  endproperty
  a_add_zero: assert property (p_add_zero) else $error("add N or Z wrong");

  property p_banked;
    @(posedge core_clk) disable iff (rst)
      phase_reg == PH_Q1 && instr[ACCESS_BIT] |=> mem_addr_reg == {$past(bank_select_register), $past(instr[7:0])};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  property p_access;
    @(posedge core_clk) disable iff (rst)
      phase_reg == PH_Q1 && !instr[ACCESS_BIT] && !ext_set_en |=> mem_addr_reg ==
      (($past(instr[7:0]) < 8'h60) ? {6'h00, $past(instr[7:0])} : {6'h3F, $past(instr[7:0])});
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong");

  property p_indexed;
    @(posedge core_clk) disable iff (rst)
      phase_reg == PH_Q1 && !instr[ACCESS_BIT] && ext_set_en && instr[7:0] <= 8'h5F
      |=> mem_addr_reg == $past(fsr2) + {6'h00, $past(instr[7:0])};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed offset address wrong");

endmodule
`default_nettype wire

/* add_and_logic_instr_exec_tb.sv */
// Self-checking bench for the add / add-with-carry / AND-literal execution core.
// Assumes one instruction every four core clocks and a combinational data memory.
`timescale 1ns/1ps
`default_nettype none
module add_and_logic_instr_exec_tb
  import alu_exec_pkg::*;
;
  logic              core_clk;
  logic              rst;
  logic [15:0]       instr;
  logic              instr_valid;
  logic              ext_set_en;
  logic [5:0]        bank_select_register;
  logic [ADDR_W-1:0] fsr2;
  logic [ADDR_W-1:0] mem_addr;
  logic              mem_rd;
  logic              mem_we;
  logic [7:0]        mem_wdata;
  logic [7:0]        mem_rdata;
  logic [7:0]        wreg;
  logic              negative_flag;
  logic              overflow_flag;
  logic              carry_flag;
  logic              digit_carry_flag;
  logic              zero_flag;
  logic [1:0]        q_phase;
  logic              instr_done;
  logic [7:0]        mem [0:16383];
  logic [7:0]        ew;
  logic [4:0]        eflags;
  int                errors;
  int                n_compared;
  int                cycles;
  int                seed_ret;

  add_logic_exec dut_u (
    .core_clk(core_clk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
    .ext_set_en(ext_set_en), .bank_select_register(bank_select_register), .fsr2(fsr2),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .wreg(wreg), .negative_flag(negative_flag),
    .overflow_flag(overflow_flag), .carry_flag(carry_flag),
    .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
    .q_phase(q_phase), .instr_done(instr_done)
  );

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  // Read data is only good while the read strobe is up, garbage otherwise
  assign mem_rdata = (mem_rd === 1'b1) ? mem[mem_addr] : ~mem[mem_addr];

  always @(posedge core_clk) begin
    if (mem_we === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [13:0] exp_addr(input logic [7:0] f, input logic a, input logic e,
                                           input logic [5:0] b, input logic [13:0] x);
    if (!a && e && f <= IDX_OFFSET_MAX) return x + {6'h00, f};
    if (a) return {b, f};
    return (f < ACCESS_SPLIT) ? (ACCESS_LOW_BASE | {6'h00, f}) : (ACCESS_HIGH_BASE | {6'h00, f});
  endfunction

  task automatic do_reset();
    rst = 1'b1;
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    ew = 8'h00;
    eflags = 5'h00;
    check("wreg_rst", {8'h00, wreg}, 16'h0000);
    check("flags_rst", {11'h000, negative_flag, overflow_flag, carry_flag, digit_carry_flag, zero_flag}, 16'h0000);
    check("phase_rst", {14'h0000, q_phase}, 16'h0000);
    check("strobes_rst", {13'h0000, mem_rd, mem_we, instr_done}, 16'h0000);
  endtask

  // One instruction, entered in the Q1 cycle, checked in Q2, in Q4 and in the next Q1
  task automatic exec(input logic [15:0] word, input logic valid, input logic e,
                      input logic [5:0] b, input logic [13:0] x);
    logic [7:0]  m;
    logic [7:0]  r;
    logic [8:0]  s;
    logic [4:0]  h;
    logic        cin;
    logic        is_add;
    logic        is_and;
    logic        d;
    logic [13:0] ea;
    instr = word;
    instr_valid = valid;
    ext_set_en = e;
    bank_select_register = b;
    fsr2 = x;
    is_add = valid && (word[15:10] == OPC_ADD_FILE || word[15:10] == OPC_ADD_CARRY);
    is_and = valid && word[15:8] == OPC_AND_LIT;
    d = word[DEST_BIT];
    ea = exp_addr(word[7:0], word[ACCESS_BIT], e, b, x);
    m = mem[ea];
    cin = (word[15:10] == OPC_ADD_CARRY) ? eflags[2] : 1'b0;
    s = {1'b0, ew} + {1'b0, m} + {8'h00, cin};
    h = {1'b0, ew[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
    r = is_and ? (ew & word[7:0]) : s[7:0];
    @(posedge core_clk);
    #1;
    instr = 16'($urandom);
    instr_valid = 1'($urandom);
    ext_set_en = 1'($urandom);
    bank_select_register = 6'($urandom);
    fsr2 = 14'($urandom);
    check("q_phase_q2", {14'h0000, q_phase}, 16'h0001);
    check("mem_rd", {15'h0000, mem_rd}, {15'h0000, is_add});
    if (is_add) check("mem_addr", {2'b00, mem_addr}, {2'b00, ea});
    repeat (2) @(posedge core_clk);
    #1;
    check("mem_we", {15'h0000, mem_we}, {15'h0000, is_add && d});
    if (is_add && d) check("mem_wdata", {8'h00, mem_wdata}, {8'h00, r});
    @(posedge core_clk);
    #1;
    if (is_add) begin
      eflags = {r[7], (ew[7] == m[7]) && (s[7] != ew[7]), s[8], h[4], r == 8'h00};
      if (!d) ew = r;
    end
    if (is_and) begin
      ew = r;
      eflags[4] = r[7];
      eflags[0] = (r == 8'h00);
    end
    check("wreg", {8'h00, wreg}, {8'h00, ew});
    check("flags", {11'h000, negative_flag, overflow_flag, carry_flag, digit_carry_flag, zero_flag},
          {11'h000, eflags});
    check("instr_done", {15'h0000, instr_done}, {15'h0000, is_add || is_and});
    check("q_phase_q1", {14'h0000, q_phase}, 16'h0000);
  endtask

  initial begin
    rst = 1'b1;
    instr = 16'h0000;
    instr_valid = 1'b0;
    ext_set_en = 1'b0;
    bank_select_register = 6'h00;
    fsr2 = 14'h0000;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    seed_ret = $urandom(32'h6b8b3ff0);
    for (int i = 0; i < 16384; i++) mem[i] = 8'($urandom);
    @(posedge core_clk);
    #1;
    do_reset();
    $display("test reset done");
    mem[14'h0010] = 8'h17;
    mem[14'h0020] = 8'hC2;
    mem[14'h0030] = 8'hCA;
    exec({OPC_ADD_FILE, 1'b0, 1'b0, 8'h10}, 1'b1, 1'b0, 6'h00, 14'h0000);
    exec({OPC_ADD_FILE, 1'b0, 1'b0, 8'h20}, 1'b1, 1'b0, 6'h00, 14'h0000);
    check("wreg_sum", {8'h00, wreg}, 16'h00D9);
    check("file_kept", {8'h00, mem[14'h0020]}, 16'h00C2);
    exec({OPC_ADD_FILE, 1'b0, 1'b0, 8'h30}, 1'b1, 1'b0, 6'h00, 14'h0000);
    exec({OPC_AND_LIT, 8'h5F}, 1'b1, 1'b0, 6'h00, 14'h0000);
    check("wreg_and", {8'h00, wreg}, 16'h0003);
    $display("test examples done");
    mem[14'h0040] = 8'hFC;
    exec({OPC_ADD_CARRY, 1'b0, 1'b0, 8'h40}, 1'b1, 1'b0, 6'h00, 14'h0000);
    check("wreg_carry", {8'h00, wreg}, 16'h0000);
    exec({OPC_ADD_CARRY, 1'b1, 1'b1, 8'h80}, 1'b1, 1'b1, 6'h05, 14'h1234);
    exec({OPC_ADD_FILE, 1'b1, 1'b0, 8'h60}, 1'b1, 1'b1, 6'h3F, 14'h0100);
    exec({OPC_ADD_FILE, 1'b1, 1'b0, 8'h5F}, 1'b1, 1'b1, 6'h00, 14'h3FF0);
    exec({OPC_ADD_CARRY, 1'b0, 1'b0, 8'h00}, 1'b1, 1'b1, 6'h00, 14'h0200);
    exec({OPC_ADD_FILE, 1'b1, 1'b0, 8'h40}, 1'b0, 1'b0, 6'h00, 14'h0000);
    $display("test corners done");
    for (int i = 0; i < 200; i++) begin
      case ($urandom_range(0, 4))
        0: exec({OPC_ADD_FILE, 10'($urandom)}, 1'b1, 1'($urandom), 6'($urandom), 14'($urandom));
        1: exec({OPC_ADD_CARRY, 10'($urandom)}, 1'b1, 1'($urandom), 6'($urandom), 14'($urandom));
        2: exec({OPC_AND_LIT, 8'($urandom)}, 1'b1, 1'($urandom), 6'($urandom), 14'($urandom));
        3: exec(16'($urandom), 1'b0, 1'($urandom), 6'($urandom), 14'($urandom));
        default: exec({4'hF, 12'($urandom)}, 1'b1, 1'($urandom), 6'($urandom), 14'($urandom));
      endcase
    end
    $display("test random done");
    do_reset();
    exec({OPC_AND_LIT, 8'hFF}, 1'b1, 1'b0, 6'h00, 14'h0000);
    check("zero_after_rst", {15'h0000, zero_flag}, 16'h0001);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
